// File: shared/lifecycle_pkg.sv
// Constants and types for switch monitor lifecycle control
package lifecycle_pkg;

    localparam int CLK_MHZ      = 200;
    // Factory load plus state machine start-up time
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES  = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] INIT_CNT_LAST = 8'(INIT_CYCLES - 1);

    localparam int CFG_W = 16;
    localparam int CCP_W = 8;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [CCP_W-1:0] CCP_RST = 8'h00;

    // Synchronizer lanes
    localparam int SYNC_POR = 0;
    localparam int SYNC_UV  = 1;
    localparam int SYNC_PIN = 2;
    localparam int SYNC_N   = 3;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_INIT  = 2'b01,
        ST_CHECK = 2'b10,
        ST_OPER  = 2'b11
    } state_t;

endpackage

// File: hdl/switch_monitor_lifecycle_control.sv
// Lifecycle control: init, run gating, resets and under-voltage handling
`timescale 1ns/100ps
module switch_monitor_lifecycle_control (
    // Clock and reset
    input  wire logic                             clock_i,
    input  wire logic                             nrst_i,
    // Asynchronous supply comparators and reset pin
    input  wire logic                             supply_ok_i,
    input  wire logic                             supply_uv_i,
    input  wire logic                             reset_pin_i,
    // Factory self-check result
    input  wire logic                             selfcheck_ok_i,
    // Main control register write
    input  wire logic                             ctrl_wr_i,
    input  wire logic                             run_wr_i,
    input  wire logic                             crc_req_wr_i,
    input  wire logic                             sw_reset_wr_i,
    // Configuration writes
    input  wire logic                             cfg_wr_i,
    input  wire logic [lifecycle_pkg::CFG_W-1:0]  cfg_data_i,
    input  wire logic                             ccp_wr_i,
    input  wire logic [lifecycle_pkg::CCP_W-1:0]  ccp_data_i,
    // Serial transaction events
    input  wire logic                             cs_rise_i,
    input  wire logic                             stat_read_i,
    // Poller events
    input  wire logic                             poll_cycle_done_i,
    input  wire logic                             switch_change_i,
    // Control outputs
    output logic                                  run_o,
    output logic                                  monitor_en_o,
    output logic                                  spi_ready_o,
    output logic                                  crc_start_o,
    output logic                                  poll_restart_o,
    output logic                                  baseline_load_o,
    output logic [lifecycle_pkg::CFG_W-1:0]       config_o,
    output logic [lifecycle_pkg::CCP_W-1:0]       clean_current_config_o,
    // Interrupt and status
    output logic                                  int_n_o,
    output logic                                  por_flag_o,
    output logic                                  por_serial_flag_o,
    output logic                                  selfcheck_error_flag_o,
    output logic                                  undervoltage_flag_o,
    output logic                                  switch_change_event_o,
    output logic                                  undervoltage_live_bit_o,
    output logic                                  other_interrupt_serial_flag_o
);
    import lifecycle_pkg::*;

    logic [SYNC_N-1:0] async_in;
    logic [SYNC_N-1:0] meta_reg;
    logic [SYNC_N-1:0] sync_reg;

    assign async_in[SYNC_POR] = supply_ok_i;
    assign async_in[SYNC_UV]  = supply_uv_i;
    assign async_in[SYNC_PIN] = reset_pin_i;

    // Zero reset keeps the supply lane low, so the device starts halted
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= async_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    logic por_ok_s;
    logic uv_s;
    logic pin_s;
    assign por_ok_s = sync_reg[SYNC_POR];
    assign uv_s     = sync_reg[SYNC_UV];
    assign pin_s    = sync_reg[SYNC_PIN];

    // Lifecycle state
    state_t             state_reg, state_next;
    logic [7:0]         init_cnt_reg, init_cnt_next;
    logic               run_reg, run_next;
    logic [CFG_W-1:0]   cfg_reg, cfg_next;
    logic [CCP_W-1:0]   clean_current_config_reg, clean_current_config_next;
    logic               por_reg, por_next;
    logic               chk_reg, chk_next;
    logic               uvf_reg, uvf_next;
    logic               ssc_reg, ssc_next;
    logic               uv_live_reg, uv_live_next;
    logic               await_reg, await_next;
    logic               crc_reg, crc_next;
    logic               restart_reg, restart_next;
    logic               base_reg, base_next;

    logic halt;
    logic sw_rst;
    logic clear_all;
    logic oper;
    logic stat_clr;
    logic uv_entry;
    logic uv_exit;
    logic first_poll;

    assign oper       = (state_reg == ST_OPER);
    // Pin high or supply below threshold halts everything
    assign halt       = !por_ok_s || pin_s;
    assign sw_rst     = oper && ctrl_wr_i && sw_reset_wr_i;
    assign clear_all  = halt || sw_rst;
    // Clear only when the status was read in the frame
    assign stat_clr   = cs_rise_i && stat_read_i;
    // Edge based, so one interrupt per transition
    assign uv_entry   = uv_s && !uv_live_reg;
    assign uv_exit    = !uv_s && uv_live_reg;
    assign first_poll = await_reg && poll_cycle_done_i && !uv_live_reg;

    always_comb begin
        state_next                = state_reg;
        init_cnt_next             = init_cnt_reg;
        run_next                  = run_reg;
        cfg_next                  = cfg_reg;
        clean_current_config_next = clean_current_config_reg;
        por_next                  = por_reg;
        chk_next                  = chk_reg;
        uvf_next                  = uvf_reg;
        ssc_next                  = ssc_reg;
        uv_live_next              = uv_live_reg;
        await_next                = await_reg;
        crc_next                  = 1'b0;
        restart_next              = 1'b0;
        base_next                 = 1'b0;
        if (clear_all) begin
            // Everything back to defaults; halt parks in OFF
            state_next                = halt ? ST_OFF : ST_INIT;
            init_cnt_next             = 8'h00;
            run_next                  = 1'b0;
            cfg_next                  = CFG_RST;
            clean_current_config_next = CCP_RST;
            por_next                  = 1'b0;
            chk_next                  = 1'b0;
            uvf_next                  = 1'b0;
            ssc_next                  = 1'b0;
            uv_live_next              = 1'b0;
            await_next                = 1'b0;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    // Release of pin or supply restarts init
                    state_next    = ST_INIT;
                    init_cnt_next = 8'h00;
                end
                ST_INIT: begin
                    if (init_cnt_reg == INIT_CNT_LAST) begin
                        state_next = ST_CHECK;
                    end else begin
                        init_cnt_next = init_cnt_reg + 8'h01;
                    end
                end
                ST_CHECK: begin
                    por_next   = 1'b1;
                    chk_next   = !selfcheck_ok_i;
                    state_next = ST_OPER;
                end
                ST_OPER: begin
                    if (ctrl_wr_i) begin
                        run_next = run_wr_i;
                    end
                    // Checksum request regardless of run bit
                    crc_next = ctrl_wr_i && crc_req_wr_i;
                    if (cfg_wr_i && !run_reg) begin
                        cfg_next = cfg_data_i;
                    end
                    if (ccp_wr_i) begin
                        clean_current_config_next = ccp_data_i;
                    end
                    // Under-voltage only touches its own bits
                    uv_live_next = uv_s;
                    // Recovery restarts polling at first channel
                    restart_next = uv_exit;
                    if (uv_exit) begin
                        await_next = 1'b1;
                    end else if (first_poll) begin
                        await_next = 1'b0;
                    end
                    // First cycle after recovery is the baseline
                    base_next = first_poll;
                    // Set wins over a same-cycle clear
                    por_next = por_reg && !stat_clr;
                    chk_next = chk_reg && !stat_clr;
                    // Flag on entry, and again on exit
                    uvf_next = (uvf_reg && !stat_clr) || uv_entry || uv_exit;
                    ssc_next = (ssc_reg && !stat_clr) || switch_change_i || first_poll;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg                <= ST_OFF;
            init_cnt_reg             <= 8'h00;
            run_reg                  <= 1'b0;
            cfg_reg                  <= CFG_RST;
            clean_current_config_reg <= CCP_RST;
            por_reg                  <= 1'b0;
            chk_reg                  <= 1'b0;
            uvf_reg                  <= 1'b0;
            ssc_reg                  <= 1'b0;
            uv_live_reg              <= 1'b0;
            await_reg                <= 1'b0;
            crc_reg                  <= 1'b0;
            restart_reg              <= 1'b0;
            base_reg                 <= 1'b0;
        end else begin
            state_reg                <= state_next;
            init_cnt_reg             <= init_cnt_next;
            run_reg                  <= run_next;
            cfg_reg                  <= cfg_next;
            clean_current_config_reg <= clean_current_config_next;
            por_reg                  <= por_next;
            chk_reg                  <= chk_next;
            uvf_reg                  <= uvf_next;
            ssc_reg                  <= ssc_next;
            uv_live_reg              <= uv_live_next;
            await_reg                <= await_next;
            crc_reg                  <= crc_next;
            restart_reg              <= restart_next;
            base_reg                 <= base_next;
        end
    end

    // Wetting and monitoring need run and no under-voltage
    assign monitor_en_o                  = oper && run_reg && !uv_live_reg;
    assign run_o                         = run_reg;
    assign spi_ready_o                   = oper;
    assign crc_start_o                   = crc_reg;
    assign poll_restart_o                = restart_reg;
    assign baseline_load_o               = base_reg;
    assign config_o                      = cfg_reg;
    assign clean_current_config_o        = clean_current_config_reg;
    assign int_n_o                       = !(por_reg || chk_reg || uvf_reg || ssc_reg);
    assign por_flag_o                    = por_reg;
    assign por_serial_flag_o             = por_reg;
    assign selfcheck_error_flag_o        = chk_reg;
    assign undervoltage_flag_o           = uvf_reg;
    assign switch_change_event_o         = ssc_reg;
    assign undervoltage_live_bit_o       = uv_live_reg;
    assign other_interrupt_serial_flag_o = uv_live_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_uv_enter;
        oper && !clear_all && uv_entry;
    endsequence
    sequence s_uv_leave;
        oper && !clear_all && uv_exit;
    endsequence

    chk_halt_clears: assert property ($rose(pin_s) |=> !spi_ready_o && !monitor_en_o
        && config_o == CFG_RST && int_n_o) else $error("reset pin did not clear device");
    chk_init_length: assert property (state_reg == ST_CHECK |->
        $past(init_cnt_reg) == INIT_CNT_LAST) else $error("init length wrong");
    chk_por_flag: assert property (state_reg == ST_CHECK && !halt |=>
        por_flag_o && por_serial_flag_o && !int_n_o) else $error("power-on flag missing");
    chk_selfcheck: assert property (state_reg == ST_CHECK && !halt |=>
        selfcheck_error_flag_o == !$past(selfcheck_ok_i)) else $error("self-check flag wrong");
    chk_cfg_lock: assert property (oper && cfg_wr_i && run_reg && !clear_all |=>
        $stable(config_o)) else $error("config written while running");
    chk_run_gate: assert property (monitor_en_o |-> run_o && !undervoltage_live_bit_o)
        else $error("monitoring without run or during under-voltage");
    chk_uv_entry: assert property (s_uv_enter |=> undervoltage_flag_o
        && undervoltage_live_bit_o && other_interrupt_serial_flag_o && !int_n_o && !monitor_en_o)
        else $error("under-voltage entry not signalled");
    chk_uv_exit: assert property (s_uv_leave |=> undervoltage_flag_o
        && !undervoltage_live_bit_o && poll_restart_o ##1 !poll_restart_o)
        else $error("under-voltage exit not signalled");
    chk_int_release: assert property (oper && !clear_all && stat_clr && !uv_entry
        && !uv_exit && !switch_change_i && !first_poll |=> int_n_o)
        else $error("interrupt not released");
    chk_baseline: assert property (oper && !clear_all && first_poll |=>
        switch_change_event_o && baseline_load_o) else $error("baseline event missing");
    chk_sw_reset: assert property (sw_rst && !halt |=> state_reg == ST_INIT
        && config_o == CFG_RST && !run_o) else $error("software reset did not reinit");
    chk_crc_run: assert property (oper && !clear_all && ctrl_wr_i && crc_req_wr_i |=>
        crc_start_o) else $error("checksum request lost");
    chk_run_stop: assert property (oper && !clear_all && ctrl_wr_i && !run_wr_i |=>
        !run_o && !monitor_en_o) else $error("run bit clear did not stop monitoring");
    chk_uv_persist: assert property (oper && !clear_all && uv_live_reg && uv_s
        && !undervoltage_flag_o |=> !undervoltage_flag_o)
        else $error("under-voltage interrupt repeated");
    chk_pin_hold: assert property (pin_s |=> !spi_ready_o && !run_o && int_n_o)
        else $error("device active while reset pin high");
    chk_ccp_write: assert property (oper && !clear_all && ccp_wr_i |=>
        clean_current_config_o == $past(ccp_data_i)) else $error("clean-current write lost");

endmodule // switch_monitor_lifecycle_control

// File: testbench/host_model.sv
// Host microcontroller model: control writes, status frames, reset pin
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic                            clock_i,
    // Main control write
    output logic                                 ctrl_wr_o,
    output logic                                 run_wr_o,
    output logic                                 crc_req_wr_o,
    output logic                                 sw_reset_wr_o,
    // Configuration writes
    output logic                                 cfg_wr_o,
    output logic [lifecycle_pkg::CFG_W-1:0]      cfg_data_o,
    output logic                                 ccp_wr_o,
    output logic [lifecycle_pkg::CCP_W-1:0]      ccp_data_o,
    // Serial frame end and reset pin
    output logic                                 cs_rise_o,
    output logic                                 stat_read_o,
    output logic                                 reset_pin_o
);
    import lifecycle_pkg::*;

    initial begin
        {ctrl_wr_o, run_wr_o, crc_req_wr_o, sw_reset_wr_o} = 4'h0;
        {cfg_wr_o, ccp_wr_o, cs_rise_o, stat_read_o, reset_pin_o} = 5'h00;
        cfg_data_o = 16'h5a5a;
        ccp_data_o = 8'ha5;
    end

    // Run and resets; released bits are inverted, not held
    task automatic ctrl_write(input logic run, input logic crc, input logic swr);
        @(negedge clock_i);
        {ctrl_wr_o, run_wr_o, crc_req_wr_o, sw_reset_wr_o} = {1'b1, run, crc, swr};
        @(negedge clock_i);
        {ctrl_wr_o, run_wr_o, crc_req_wr_o, sw_reset_wr_o} = {1'b0, ~run, ~crc, ~swr};
    endtask

    task automatic cfg_write(input logic [CFG_W-1:0] d);
        @(negedge clock_i);
        {cfg_wr_o, cfg_data_o} = {1'b1, d};
        @(negedge clock_i);
        {cfg_wr_o, cfg_data_o} = {1'b0, ~d};
    endtask

    task automatic ccp_write(input logic [CCP_W-1:0] d);
        @(negedge clock_i);
        {ccp_wr_o, ccp_data_o} = {1'b1, d};
        @(negedge clock_i);
        {ccp_wr_o, ccp_data_o} = {1'b0, ~d};
    endtask

    task automatic status_frame(input logic rd);
        @(negedge clock_i);
        {cs_rise_o, stat_read_o} = {1'b1, rd};
        @(negedge clock_i);
        {cs_rise_o, stat_read_o} = {1'b0, ~rd};
    endtask

    task automatic hw_reset(input int n);
        @(negedge clock_i);
        reset_pin_o = 1'b1;
        repeat (n) @(negedge clock_i);
        reset_pin_o = 1'b0;
    endtask
endmodule // host_model

// File: testbench/switch_monitor_lifecycle_control_tb_top.sv
// Self-checking testbench for the lifecycle control block
`timescale 1ns/100ps
module switch_monitor_lifecycle_control_tb_top;
    import lifecycle_pkg::*;

    logic             clock_i, nrst_i, supply_ok_i, supply_uv_i, selfcheck_ok_i;
    logic             reset_pin_i, ctrl_wr_i, run_wr_i, crc_req_wr_i, sw_reset_wr_i;
    logic             cfg_wr_i, ccp_wr_i, cs_rise_i, stat_read_i, poll_done, sw_change;
    logic [CFG_W-1:0] cfg_data_i, d;
    logic [CCP_W-1:0] ccp_data_i, c;
    logic             run_o, mon_en, rdy, crc_st, restart, baseline, int_n, por, por_s;
    logic             sc_err, uv_flag, change_ev, uv_live, oi_flag;
    logic [CFG_W-1:0] config_o;
    logic [CCP_W-1:0] ccp_o;
    logic [2:0]       pulse_q[$];
    int               num_errors, n_tests;
    integer           seed;

    switch_monitor_lifecycle_control u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
        .supply_ok_i(supply_ok_i), .supply_uv_i(supply_uv_i), .reset_pin_i(reset_pin_i),
        .selfcheck_ok_i(selfcheck_ok_i), .ctrl_wr_i(ctrl_wr_i), .run_wr_i(run_wr_i),
        .crc_req_wr_i(crc_req_wr_i), .sw_reset_wr_i(sw_reset_wr_i), .cfg_wr_i(cfg_wr_i),
        .cfg_data_i(cfg_data_i), .ccp_wr_i(ccp_wr_i), .ccp_data_i(ccp_data_i),
        .cs_rise_i(cs_rise_i), .stat_read_i(stat_read_i), .poll_cycle_done_i(poll_done),
        .switch_change_i(sw_change), .run_o(run_o), .monitor_en_o(mon_en),
        .spi_ready_o(rdy), .crc_start_o(crc_st), .poll_restart_o(restart),
        .baseline_load_o(baseline), .config_o(config_o), .clean_current_config_o(ccp_o),
        .int_n_o(int_n), .por_flag_o(por), .por_serial_flag_o(por_s),
        .selfcheck_error_flag_o(sc_err), .undervoltage_flag_o(uv_flag),
        .switch_change_event_o(change_ev), .undervoltage_live_bit_o(uv_live),
        .other_interrupt_serial_flag_o(oi_flag));

    host_model u_host (.clock_i(clock_i), .ctrl_wr_o(ctrl_wr_i), .run_wr_o(run_wr_i),
        .crc_req_wr_o(crc_req_wr_i), .sw_reset_wr_o(sw_reset_wr_i), .cfg_wr_o(cfg_wr_i),
        .cfg_data_o(cfg_data_i), .ccp_wr_o(ccp_wr_i), .ccp_data_o(ccp_data_i),
        .cs_rise_o(cs_rise_i), .stat_read_o(stat_read_i), .reset_pin_o(reset_pin_i));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic compare(input string name, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    // Order: por, por serial, self-check, uv flag, uv live, other int, int_n
    task automatic check_flags(input logic [6:0] e);
        compare("flags", 16'(e), 16'({por, por_s, sc_err, uv_flag, uv_live, oi_flag, int_n}));
    endtask

    task automatic check_ctl(input logic [2:0] e);
        compare("ready_run_monitor", 16'(e), 16'({rdy, run_o, mon_en}));
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 400) begin
            @(negedge clock_i);
            k++;
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Pulse results are matched against the oldest note
    always @(negedge clock_i) begin
        if ((crc_st | restart | baseline) === 1'b1) begin
            compare("pulses", 16'(pulse_q.size() > 0 ? pulse_q.pop_front() : 3'b000),
                    16'({crc_st, restart, baseline}));
        end
    end

    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        num_errors = 0;
        n_tests = 0;
        seed = 32'h512e;
        {nrst_i, supply_uv_i, selfcheck_ok_i, poll_done, sw_change} = 5'h00;
        supply_ok_i = 1'b1;
        repeat (4) @(negedge clock_i);
        nrst_i = 1'b1;
        @(negedge clock_i);
        check_ctl(3'b000);
        wait_ready();
        check_flags(7'b1110000);
        u_host.status_frame(1'b0);
        check_flags(7'b1110000);
        u_host.status_frame(1'b1);
        check_flags(7'b0000001);
        selfcheck_ok_i = 1'b1;
        d = 16'($random(seed));
        u_host.cfg_write(d);
        compare("config", d, config_o);
        u_host.ctrl_write(1'b0, 1'b0, 1'b1);
        check_ctl(3'b000);
        wait_ready();
        check_flags(7'b1100000);
        compare("config", CFG_RST, config_o);
        u_host.status_frame(1'b1);
        d = 16'($random(seed));
        c = 8'($random(seed));
        u_host.cfg_write(d);
        u_host.ctrl_write(1'b1, 1'b0, 1'b0);
        check_ctl(3'b111);
        u_host.cfg_write(~d);
        compare("config", d, config_o);
        u_host.ccp_write(c);
        compare("clean_current", 16'(c), 16'(ccp_o));
        pulse_q.push_back(3'b100);
        u_host.ctrl_write(1'b1, 1'b1, 1'b0);
        repeat (2) @(negedge clock_i);
        u_host.ctrl_write(1'b0, 1'b0, 1'b0);
        check_ctl(3'b100);
        u_host.cfg_write(~d);
        compare("config", ~d, config_o);
        u_host.ctrl_write(1'b1, 1'b0, 1'b0);
        supply_uv_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check_flags(7'b0001110);
        check_ctl(3'b110);
        compare("config", ~d, config_o);
        u_host.status_frame(1'b1);
        check_flags(7'b0000111);
        repeat (20) @(negedge clock_i);
        check_flags(7'b0000111);
        pulse_q.push_back(3'b010);
        supply_uv_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check_flags(7'b0001000);
        check_ctl(3'b111);
        u_host.status_frame(1'b1);
        pulse_q.push_back(3'b001);
        poll_done = 1'b1;
        @(negedge clock_i);
        poll_done = 1'b0;
        @(negedge clock_i);
        compare("change_event", 16'h0001, 16'(change_ev));
        u_host.status_frame(1'b1);
        sw_change = 1'b1;
        @(negedge clock_i);
        sw_change = 1'b0;
        compare("change_event", 16'h0001, 16'(change_ev));
        check_flags(7'b0000000);
        u_host.status_frame(1'b1);
        check_flags(7'b0000001);
        selfcheck_ok_i = 1'($random(seed));
        u_host.hw_reset(400);
        check_ctl(3'b000);
        check_flags(7'b0000001);
        compare("config", CFG_RST, config_o);
        wait_ready();
        check_flags({2'b11, ~selfcheck_ok_i, 4'b0000});
        u_host.cfg_write(d);
        u_host.ctrl_write(1'b1, 1'b0, 1'b0);
        supply_ok_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check_ctl(3'b000);
        compare("config", CFG_RST, config_o);
        supply_ok_i = 1'b1;
        wait_ready();
        check_flags({2'b11, ~selfcheck_ok_i, 4'b0000});
        u_host.cfg_write(d);
        compare("config", d, config_o);
        nrst_i = 1'b0;
        @(negedge clock_i);
        check_ctl(3'b000);
        check_flags(7'b0000001);
        compare("config", CFG_RST, config_o);
        @(negedge clock_i);
        nrst_i = 1'b1;
        wait_ready();
        check_flags({2'b11, ~selfcheck_ok_i, 4'b0000});
        compare("pending_pulses", 16'h0000, 16'(pulse_q.size()));
        close_out();
    end
endmodule // switch_monitor_lifecycle_control_tb_top
